// ### ee2w_pkg.sv
// shared constants for the two-wire eeprom slave and its master
package ee2w_pkg;
  // slave address layout
  localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
  localparam int ADDR_TYPE_MSB = 7;
  localparam int ADDR_TYPE_LSB = 4;
  localparam int ADDR_SEL_HIGH_POS = 3;
  localparam int ADDR_SEL_LOW_POS = 2;
  localparam int ADDR_BLOCK_POS = 1;
  localparam int ADDR_DIR_POS = 0;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  // array shape
  localparam int BLOCK_COUNT = 2;
  localparam int BLOCK_BYTES = 256;
  localparam int ARRAY_BYTES = BLOCK_COUNT * BLOCK_BYTES;
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int WRITE_CYCLE_MS = 10;
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_MS * (CLK_HZ / 1000));
  localparam int BUS_HALF_CYC = 25;
  // byte reset value
  localparam logic [7:0] BYTE_RESET = 8'hFF;
endpackage : ee2w_pkg

// ### ee2w_if.sv
// two-wire bus between the eeprom slave and the bus master
`timescale 1ns/1ps
interface ee2w_if;
  logic scl;
  logic sda_mst_out;
  logic sda_mst_oe;
  logic sda_slv_out;
  logic sda_slv_oe;
  logic sda;
  // open-drain resolution with pull-up
  assign sda = !((sda_mst_oe && !sda_mst_out) || (sda_slv_oe && !sda_slv_out));

  modport slave (
    input scl,
    input sda,
    output sda_slv_out,
    output sda_slv_oe
  );

  modport master (
    input sda,
    output scl,
    output sda_mst_out,
    output sda_mst_oe
  );
endinterface : ee2w_if

// ### ee2w_slave.sv
// eeprom end: start/stop detect, address match, byte write, read handshake
`timescale 1ns/1ps
module ee2w_slave #(
  parameter int WRITE_CYC = ee2w_pkg::WRITE_CYCLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus side
  ee2w_if.slave bus,
  // select pins
  input wire logic device_select_pin_high,
  input wire logic device_select_pin_low,
  // status
  output logic busy,
  output logic standby,
  output logic [7:0] last_written
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WORD = 3'b010,
    ST_DATA = 3'b011,
    ST_SEND = 3'b100,
    ST_WAITSTOP = 3'b101
  } ee2w_st_t;

  typedef struct packed {
    logic scl_d;
    logic sda_d;
    ee2w_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic in_ack;
    logic page_block_select_bit;
    logic [7:0] word_addr;
    logic [7:0] wdata;
    logic wpend;
    logic [31:0] wcnt;
    logic busy;
    logic standby;
    logic need_stop;
    logic sda_oe;
    logic [7:0] last;
    logic [7:0] txbyte;
  } ee2w_slv_state_t;

  ee2w_slv_state_t s_ff;
  ee2w_slv_state_t nxt_s;
  logic [7:0] mem_ff [ee2w_pkg::ARRAY_BYTES];
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  logic [8:0] mem_idx;
  logic commit;

  ////////////////////////////////////////////////////////////////////
  // bus condition detection
  // edges with scl high only
  assign start_ev = s_ff.scl_d && bus.scl && s_ff.sda_d && !bus.sda;
  assign stop_ev = s_ff.scl_d && bus.scl && !s_ff.sda_d && bus.sda;
  assign scl_rise = !s_ff.scl_d && bus.scl;
  assign scl_fall = s_ff.scl_d && !bus.scl;
  assign mem_idx = {s_ff.page_block_select_bit, s_ff.word_addr};
  assign commit = s_ff.busy && (s_ff.wcnt == 32'(WRITE_CYC - 1));

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.scl_d = bus.scl;
    nxt_s.sda_d = bus.sda;
    if (s_ff.busy) begin
      nxt_s.wcnt = s_ff.wcnt + 32'd1;
      if (commit) begin
        nxt_s.busy = 1'b0;
        nxt_s.wcnt = '0;
        nxt_s.last = s_ff.wdata;
      end
    end else if (start_ev) begin
      nxt_s.st = ST_ADDR;
      nxt_s.bitcnt = '0;
      nxt_s.in_ack = 1'b0;
      nxt_s.sda_oe = 1'b0;
      nxt_s.standby = 1'b0;
      nxt_s.wpend = 1'b0;
    end else if (stop_ev) begin
      nxt_s.st = ST_IDLE;
      nxt_s.sda_oe = 1'b0;
      if (s_ff.wpend) begin
        nxt_s.busy = 1'b1;
        nxt_s.wpend = 1'b0;
        nxt_s.need_stop = 1'b1;
      end else begin
        nxt_s.standby = 1'b1;
        nxt_s.need_stop = 1'b0;
      end
    end else if (s_ff.st != ST_IDLE && s_ff.st != ST_WAITSTOP) begin
      if (scl_rise && !s_ff.in_ack && s_ff.st != ST_SEND) begin
        nxt_s.shreg = {s_ff.shreg[6:0], bus.sda};
        nxt_s.bitcnt = s_ff.bitcnt + 4'd1;
      end
      if (scl_rise && s_ff.in_ack && s_ff.st == ST_SEND) begin
        if (bus.sda) begin
          nxt_s.st = ST_WAITSTOP;
        end
      end
      if (scl_fall) begin
        if (s_ff.in_ack) begin
          nxt_s.in_ack = 1'b0;
          nxt_s.bitcnt = '0;
          nxt_s.sda_oe = 1'b0;
          if (s_ff.st == ST_SEND) begin
            nxt_s.txbyte = mem_ff[mem_idx];
            nxt_s.word_addr = s_ff.word_addr + 8'd1;
            nxt_s.sda_oe = !mem_ff[mem_idx][7];
            nxt_s.bitcnt = 4'd1;
          end
        end else if (s_ff.st == ST_SEND) begin
          if (s_ff.bitcnt == 4'd8) begin
            nxt_s.in_ack = 1'b1;
            nxt_s.sda_oe = 1'b0;
          end else begin
            nxt_s.sda_oe = !s_ff.txbyte[3'(4'd7 - s_ff.bitcnt)];
            nxt_s.bitcnt = s_ff.bitcnt + 4'd1;
          end
        end else if (s_ff.bitcnt == 4'd8) begin
          unique case (s_ff.st)
            ST_ADDR: begin
              if (s_ff.shreg[ee2w_pkg::ADDR_TYPE_MSB:ee2w_pkg::ADDR_TYPE_LSB]
                  == ee2w_pkg::DEV_TYPE_CODE
                  && s_ff.shreg[ee2w_pkg::ADDR_SEL_HIGH_POS] == device_select_pin_high
                  && s_ff.shreg[ee2w_pkg::ADDR_SEL_LOW_POS] == device_select_pin_low) begin
                nxt_s.in_ack = 1'b1;
                nxt_s.sda_oe = 1'b1;
                nxt_s.page_block_select_bit = s_ff.shreg[ee2w_pkg::ADDR_BLOCK_POS];
                if (s_ff.shreg[ee2w_pkg::ADDR_DIR_POS] == ee2w_pkg::DIR_READ) begin
                  nxt_s.st = ST_SEND;
                end else begin
                  nxt_s.st = ST_WORD;
                end
              end else begin
                nxt_s.st = ST_IDLE;
              end
            end
            ST_WORD: begin
              nxt_s.word_addr = s_ff.shreg;
              nxt_s.in_ack = 1'b1;
              nxt_s.sda_oe = 1'b1;
              nxt_s.st = ST_DATA;
            end
            ST_DATA: begin
              nxt_s.wdata = s_ff.shreg;
              nxt_s.wpend = 1'b1;
              nxt_s.in_ack = 1'b1;
              nxt_s.sda_oe = 1'b1;
              nxt_s.st = ST_WAITSTOP;
            end
            default: nxt_s.st = ST_IDLE;
          endcase
        end
      end
    end
    // ack slot on the final data byte must still release after scl fall
    if (!s_ff.busy && s_ff.st == ST_WAITSTOP && s_ff.in_ack && scl_fall) begin
      nxt_s.in_ack = 1'b0;
      nxt_s.sda_oe = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_ff <= '{scl_d: 1'b1, sda_d: 1'b1, st: ST_IDLE, standby: 1'b1, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // array, written when the program period ends
  always_ff @(posedge clk) begin
    // byte lands at end of period
    if (commit) begin
      mem_ff[mem_idx] <= s_ff.wdata;
    end
  end

  // outputs; released while busy
  assign bus.sda_slv_out = 1'b0;
  assign bus.sda_slv_oe = s_ff.sda_oe;
  assign busy = s_ff.busy;
  assign standby = s_ff.standby;
  assign last_written = s_ff.last;
endmodule : ee2w_slave

// ### ee2w_master.sv
// bus master end: byte write and single byte read
`timescale 1ns/1ps
module ee2w_master #(
  parameter int HALF_CYC = ee2w_pkg::BUS_HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus side
  ee2w_if.master bus,
  // user request
  input wire logic req,
  input wire logic req_read,
  input wire logic [7:0] req_slave_addr,
  input wire logic [7:0] req_word,
  input wire logic [7:0] req_data,
  // user answer
  output logic done,
  output logic nacked,
  output logic [7:0] rd_data,
  output logic idle
);
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_START = 3'b001,
    MS_BYTE = 3'b010,
    MS_STOP = 3'b011,
    MS_DONE = 3'b100
  } ee2w_mst_st_t;

  typedef struct packed {
    ee2w_mst_st_t st;
    logic [15:0] tick;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [1:0] idx;
    logic [7:0] sh;
    logic [7:0] rx;
    logic scl;
    logic sda;
    logic rd;
    logic [23:0] bytes;
    logic done;
    logic nacked;
    logic idle;
  } ee2w_mst_state_t;

  ee2w_mst_state_t m_ff;
  ee2w_mst_state_t nxt_m;
  logic tick_end;
  logic last_idx;

  assign tick_end = (m_ff.tick == 16'(HALF_CYC - 1));
  // a read ends after its one data byte, a write after address, word and data
  assign last_idx = m_ff.rd ? (m_ff.idx == 2'd1) : (m_ff.idx == 2'd2);

  ////////////////////////////////////////////////////////////////////
  // next state; each bit is four quarter steps, sda moves with scl low
  always_comb begin
    nxt_m = m_ff;
    nxt_m.done = 1'b0;
    nxt_m.tick = tick_end ? 16'h0000 : m_ff.tick + 16'h0001;
    unique case (m_ff.st)
      MS_IDLE: begin
        nxt_m.tick = '0;
        nxt_m.idle = 1'b1;
        if (req) begin
          nxt_m.st = MS_START;
          nxt_m.idle = 1'b0;
          nxt_m.nacked = 1'b0;
          nxt_m.rd = req_read;
          nxt_m.bytes = {req_slave_addr, req_word, req_data};
          nxt_m.phase = '0;
        end
      end
      MS_START: if (tick_end) begin
        nxt_m.phase = m_ff.phase + 2'd1;
        if (m_ff.phase == 2'd0) nxt_m.sda = 1'b0;
        if (m_ff.phase == 2'd1) begin
          nxt_m.scl = 1'b0;
          nxt_m.st = MS_BYTE;
          nxt_m.idx = '0;
          nxt_m.bitn = '0;
          nxt_m.sh = m_ff.bytes[23:16];
          nxt_m.phase = '0;
        end
      end
      MS_BYTE: if (tick_end) begin
        nxt_m.phase = m_ff.phase + 2'd1;
        unique case (m_ff.phase)
          2'd0: nxt_m.sda = (m_ff.bitn == 4'd8) ? 1'b1
                         : (m_ff.rd && m_ff.idx != 2'd0) ? 1'b1 : m_ff.sh[7];
          2'd1: nxt_m.scl = 1'b1;
          2'd2: begin
            if (m_ff.bitn == 4'd8) begin
              if (bus.sda && !(m_ff.rd && m_ff.idx != 2'd0)) nxt_m.nacked = 1'b1;
            end else begin
              nxt_m.rx = {m_ff.rx[6:0], bus.sda};
            end
          end
          default: begin
            nxt_m.scl = 1'b0;
            nxt_m.sh = {m_ff.sh[6:0], 1'b0};
            nxt_m.bitn = m_ff.bitn + 4'd1;
            if (m_ff.bitn == 4'd8) begin
              nxt_m.bitn = '0;
              nxt_m.idx = m_ff.idx + 2'd1;
              nxt_m.sh = (m_ff.idx == 2'd0) ? m_ff.bytes[15:8] : m_ff.bytes[7:0];
              if (m_ff.nacked || last_idx || (m_ff.rd && m_ff.idx != 2'd0)) begin
                nxt_m.st = MS_STOP;
              end
            end
          end
        endcase
      end
      MS_STOP: if (tick_end) begin
        nxt_m.phase = m_ff.phase + 2'd1;
        if (m_ff.phase == 2'd0) nxt_m.sda = 1'b0;
        if (m_ff.phase == 2'd1) nxt_m.scl = 1'b1;
        if (m_ff.phase == 2'd2) begin
          nxt_m.sda = 1'b1;
          nxt_m.st = MS_DONE;
        end
      end
      default: begin
        // done pulses for one cycle, then back to idle
        nxt_m.done = 1'b1;
        nxt_m.st = MS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk) begin
    if (reset) begin
      m_ff <= '{st: MS_IDLE, scl: 1'b1, sda: 1'b1, idle: 1'b1, default: '0};
    end else begin
      m_ff <= nxt_m;
    end
  end

  // outputs
  assign bus.scl = m_ff.scl;
  assign bus.sda_mst_out = 1'b0;
  assign bus.sda_mst_oe = !m_ff.sda;
  assign done = m_ff.done;
  assign nacked = m_ff.nacked;
  assign rd_data = m_ff.rx;
  assign idle = m_ff.idle;
endmodule : ee2w_master

// ### ee2w_properties.sv
// concurrent checks on the two-wire bus between eeprom slave and master
`timescale 1ns/1ps
module ee2w_properties #(
  parameter int WRITE_CYC = 400
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus lines
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_slv_out,
  input wire logic sda_slv_oe,
  // slave status
  input wire logic busy,
  input wire logic standby
);
  localparam int BUSY_MAX = WRITE_CYC + 2;
  localparam int BUSY_MIN = WRITE_CYC - 2;
  int busy_cnt_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////
  // length of the internal write period
  always_ff @(posedge clk) begin
    if (reset || !busy) begin
      busy_cnt_ff <= 0;
    end else begin
      busy_cnt_ff <= busy_cnt_ff + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_oe_scl_low: assert property ($changed(sda_slv_oe) |-> !scl)
    else $error("slave sda moved while scl high");
  a_standby_quiet: assert property (standby |-> !sda_slv_oe)
    else $error("slave drives sda in standby");
  a_standby_on_stop: assert property ($rose(standby) |-> scl && sda && !busy)
    else $error("standby entered without a plain stop");
  a_ack_pulls_low: assert property (sda_slv_oe |-> !sda_slv_out && !sda)
    else $error("slave drive is not low");
  a_ack_stands: assert property ($rose(sda_slv_oe) |-> sda_slv_oe [*8])
    else $error("slave drive too short");
  a_busy_on_stop: assert property ($rose(busy) |-> scl && sda)
    else $error("write cycle began without stop");
  a_busy_quiet: assert property (busy |-> !sda_slv_oe)
    else $error("slave drives sda while busy");
  a_busy_bound: assert property (busy_cnt_ff <= BUSY_MAX)
    else $error("write cycle too long");
  a_busy_full: assert property ($fell(busy) |-> busy_cnt_ff >= BUSY_MIN)
    else $error("write cycle too short");

  // main scenarios
  c_write: cover property ($rose(busy));
  c_standby: cover property ($rose(standby));
  c_ack: cover property ($rose(sda_slv_oe));
endmodule : ee2w_properties

// ### tb_top.sv
// self-checking bench: master and eeprom slave joined on one bus
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic rd;
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] d;
    logic nack;
    logic [7:0] exp;
  } ee2w_row_t;
  localparam int WC = 400;
  logic clk, reset, req, req_read, pin_hi, pin_lo;
  logic [7:0] req_slave_addr, req_word, req_data;
  logic done, nacked, idle, busy, standby;
  logic [7:0] rd_data, last_written;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  // ordinary transfers: kind, address, word, data, refused, byte
  ee2w_row_t rows [12] = '{
    '{1'b0, 8'hA8, 8'h12, 8'h5A, 1'b0, 8'h5A}, '{1'b1, 8'hA9, 8'h00, 8'h00, 1'b0, 8'h5A},
    '{1'b0, 8'hAA, 8'h12, 8'hC3, 1'b0, 8'hC3}, '{1'b1, 8'hAB, 8'h00, 8'h00, 1'b0, 8'hC3},
    '{1'b0, 8'hAA, 8'h00, 8'h3C, 1'b0, 8'h3C}, '{1'b0, 8'hAA, 8'hFF, 8'h00, 1'b0, 8'h00},
    '{1'b1, 8'hAB, 8'h00, 8'h00, 1'b0, 8'h00}, '{1'b0, 8'h28, 8'h01, 8'h11, 1'b1, 8'h00},
    '{1'b0, 8'hA4, 8'h01, 8'h22, 1'b1, 8'h00}, '{1'b0, 8'hAC, 8'h01, 8'h33, 1'b1, 8'h00},
    '{1'b1, 8'h29, 8'h00, 8'h00, 1'b1, 8'h00}, '{1'b1, 8'hAB, 8'h00, 8'h00, 1'b0, 8'h3C}};

  ////////////////////////////////////////////////////////////////////////
  ee2w_if u_ee2w_if ();
  ee2w_slave #(.WRITE_CYC(WC)) u_ee2w_slave (.clk(clk), .reset(reset), .bus(u_ee2w_if),
    .device_select_pin_high(pin_hi), .device_select_pin_low(pin_lo), .busy(busy),
    .standby(standby), .last_written(last_written));
  ee2w_master u_ee2w_master (.clk(clk), .reset(reset), .bus(u_ee2w_if), .req(req),
    .req_read(req_read), .req_slave_addr(req_slave_addr), .req_word(req_word),
    .req_data(req_data), .done(done), .nacked(nacked), .rd_data(rd_data), .idle(idle));
  ee2w_properties #(.WRITE_CYC(WC)) u_ee2w_properties (.clk(clk), .reset(reset),
    .scl(u_ee2w_if.scl), .sda(u_ee2w_if.sda), .sda_slv_out(u_ee2w_if.sda_slv_out),
    .sda_slv_oe(u_ee2w_if.sda_slv_oe), .busy(busy), .standby(standby));

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      fail_count++;
      close_out();
    end
  end

  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one transfer through the master, bounded wait for done
  task automatic xfer(input logic rd, input logic [7:0] a, input logic [7:0] w,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    req_read <= rd;
    req_slave_addr <= a;
    req_word <= w;
    req_data <= d;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    while (done !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 8000) begin
      fail_count++;
    end
  endtask : xfer

  // bounded wait for the write period to end
  task automatic wait_free();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < WC + 100) begin
      @(negedge clk);
      n++;
    end
    check("busy end", {7'h00, busy}, 8'h00);
  endtask : wait_free

  // reset state of both ends
  task automatic check_rst();
    check("standby", {7'h00, standby}, 8'h01);
    check("busy", {7'h00, busy}, 8'h00);
    check("idle", {7'h00, idle}, 8'h01);
    check("done", {7'h00, done}, 8'h00);
    check("lines", {6'h00, u_ee2w_if.scl, u_ee2w_if.sda}, 8'h03);
  endtask : check_rst

  // verdict and end of run
  task automatic close_out();
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset = 1'b1;
    req = 1'b0;
    req_read = 1'b0;
    req_slave_addr = 8'h00;
    req_word = 8'h00;
    req_data = 8'h00;
    pin_hi = 1'b1;
    pin_lo = 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check_rst();
    // table of ordinary transfers
    foreach (rows[i]) begin
      xfer(rows[i].rd, rows[i].a, rows[i].w, rows[i].d);
      check("nacked", {7'h00, nacked}, {7'h00, rows[i].nack});
      if (rows[i].rd && !rows[i].nack) begin
        check("rd_data", rd_data, rows[i].exp);
        check("standby", {7'h00, standby}, 8'h01);
      end
      if (!rows[i].rd && !rows[i].nack) begin
        check("busy", {7'h00, busy}, 8'h01);
        check("standby", {7'h00, standby}, 8'h00);
        wait_free();
      end
      // committed byte shows only once the write period is over
      if (!rows[i].rd) begin
        check("last_written", last_written, rows[i].exp);
      end
    end
    // request during the write period is ignored, then accepted
    xfer(1'b0, 8'hA8, 8'h30, 8'h77);
    xfer(1'b0, 8'hA8, 8'h31, 8'h99);
    check("nacked busy", {7'h00, nacked}, 8'h01);
    check("last_written", last_written, 8'h77);
    wait_free();
    xfer(1'b0, 8'hA8, 8'h31, 8'h99);
    check("nacked free", {7'h00, nacked}, 8'h00);
    wait_free();
    check("last_written", last_written, 8'h99);
    // reset in the middle of a write period
    xfer(1'b0, 8'hA8, 8'h32, 8'h55);
    check("busy", {7'h00, busy}, 8'h01);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check_rst();
    xfer(1'b0, 8'hAA, 8'h41, 8'h22);
    check("nacked", {7'h00, nacked}, 8'h00);
    wait_free();
    check("last_written", last_written, 8'h22);
    close_out();
  end
endmodule : tb_top
